// *** hdl/pin_select_defs.vh ***
// Purpose: constants for the peripheral pin select matrix
// Assumes: 32-bit classic Wishbone, byte addresses, one register per word
// Notes:   selection fields are 5 bits wide in the low bits of each word
`ifndef PIN_SELECT_DEFS_VH
`define PIN_SELECT_DEFS_VH

// word indices of the register map (byte address = 4 * index)
`define LOCK_WORD        8'h00
`define IN_SEL_BASE      8'h10
`define OUT_SEL_BASE     8'h40

// counts of selectors
`define NUM_IN_SEL       28
`define NUM_OUT_PINS     17

// field layout
`define SEL_W            5
`define LOCK_BIT         0

// reset values
`define OUT_SEL_RESET    5'h00
`define LOCK_RESET       1'b0

// unlock key bytes, written back to back
`define UNLOCK_KEY_A     8'h55
`define UNLOCK_KEY_B     8'hAA

// output sources that may take over the pin driver direction
`define DIR_OVR_MASK     32'h0D3F_0F00

// reserved output codes select nothing
`define OUT_CODE_RSVD1   5'h01
`define OUT_CODE_RSVD0   5'h00

// input codes that name no pin
`define IN_CODE_RSVD_LO  5'h06
`define IN_CODE_RSVD_HI  5'h0B

`endif

// *** hdl/pin_select_matrix.v ***
// Purpose: digital pin routing matrix with a lockable Wishbone register file
// Assumes: peripheral outputs and warm reset are on clk; pins are asynchronous
// Notes:   output selector j drives pin j of the list A0 A1 A2 A4 A5 B4-B7 C0-C7
//
// Summary of operation
// - output selector is 5 bits, upper bits zero
// - codes 31..28 route modulator, refclk, oscillator, timer0
// - codes 27..24 route serial data and clock lines
// - codes 23..20 route comparators and async port lines
// - codes 19..16 and 11..8 route wavegen outputs
// - codes 15..12 route capture/compare outputs four..one
// - codes 7..4 route logic cell outputs four..one
// - code 3 routes pwm six, 2 pwm five
// - marked peripherals may override pin direction control
// - lock register has one flag, bit 0
// - lock set freezes every selection register
// - lock clear lets selection writes through
// - output selectors clear only on power-on reset
// - one 5-bit input selector per peripheral input
// - one output selector per listed pin
// - lock change only right after 55 then AA
// - one-way option allows one clear-set cycle
// - power-on reset restores selections, clears lock
// - input codes map to port A, B, C pins
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "pin_select_defs.vh"

module pin_select_matrix #(
   parameter [`NUM_IN_SEL*`SEL_W-1:0] IN_SEL_DEFAULTS = 140'h0
) (
   // clock and resets
   input  wire         clk,
   input  wire         rst_n,
   input  wire         warm_rst_n,
   // configuration strap
   input  wire         one_way_lock_option,
   // wishbone slave
   input  wire         cyc_i,
   input  wire         stb_i,
   input  wire         we_i,
   input  wire [31:0]  adr_i,
   input  wire [3:0]   sel_i,
   input  wire [31:0]  dat_i,
   output reg  [31:0]  dat_o,
   output reg          ack_o,
   // peripheral side, outputs indexed by output code, inputs by selector index
   input  wire [31:0]  periph_out,
   input  wire [31:0]  periph_dir_req,
   output reg  [27:0]  periph_in_q,
   // pin side, input indexed by input code
   input  wire [23:0]  pin_in,
   output reg  [16:0]  pin_out_q,
   output reg  [16:0]  pin_dir_ovr_q,
   // status
   output reg          selection_lock_flag
);

   // unlock sequence states
   localparam [1:0] SEQ_IDLE  = 2'b00;
   localparam [1:0] SEQ_GOT_A = 2'b01;
   localparam [1:0] SEQ_ARMED = 2'b10;

   reg  [`SEL_W-1:0] in_sel_q  [0:`NUM_IN_SEL-1];
   reg  [`SEL_W-1:0] out_sel_q [0:`NUM_OUT_PINS-1];
   reg  [1:0]        seq_q;
   reg  [1:0]        seq_d;
   reg               one_way_used_q;
   reg               one_way_cfg_q;
   reg               strap_s1_q;
   reg               strap_s2_q;
   reg  [23:0]       pin_s1_q;
   reg  [23:0]       pin_s2_q;
   reg  [31:0]       rd_d;
   reg               lock_d;
   reg               used_d;

   wire              req;
   wire              wr_fire;
   wire [7:0]        word;
   wire [7:0]        in_idx;
   wire [7:0]        out_idx;
   wire              hit_lock;
   wire              hit_in;
   wire              hit_out;
   wire              lane0;
   wire              sel_wr_ok;
   wire [31:0]       dir_mask;
   wire [31:0]       src_level;
   wire [31:0]       src_ovr;

   assign req      = cyc_i & stb_i;
   // write lands on the edge where the master samples ack
   assign wr_fire  = req & we_i & ack_o;
   assign word     = adr_i[9:2];
   assign in_idx   = word - `IN_SEL_BASE;
   assign out_idx  = word - `OUT_SEL_BASE;
   // upper address bits must be zero, else the access is unmapped
   assign hit_lock = (adr_i[31:10] == 22'h00_0000) && (word == `LOCK_WORD);
   assign hit_in   = (adr_i[31:10] == 22'h00_0000) && (word >= `IN_SEL_BASE)
                     && (in_idx < `NUM_IN_SEL);
   assign hit_out  = (adr_i[31:10] == 22'h00_0000) && (word >= `OUT_SEL_BASE)
                     && (out_idx < `NUM_OUT_PINS);
   // data sits in byte lane 0; a write without that lane changes no selection or lock, but still breaks the unlock key
   assign lane0    = sel_i[0];
   assign sel_wr_ok = wr_fire & lane0 & ~selection_lock_flag;

   // bus handshake: one wait state, ack drops the cycle after it rises
   always @(posedge clk) begin
      if (!rst_n) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req & ~ack_o;
      end
   end

   // read mux; reserved bits and unmapped words read zero
   always @* begin
      rd_d = 32'h0000_0000;
      if (hit_lock) begin
         rd_d[`LOCK_BIT] = selection_lock_flag;
      end else if (hit_in) begin
         rd_d[`SEL_W-1:0] = in_sel_q[in_idx[4:0]];
      end else if (hit_out) begin
         rd_d[`SEL_W-1:0] = out_sel_q[out_idx[4:0]];
      end
   end

   // read data captured with ack; selections stay readable even when locked
   always @(posedge clk) begin
      if (!rst_n) begin
         dat_o <= 32'h0000_0000;
      end else if (req & ~ack_o & ~we_i) begin
         dat_o <= rd_d;
      end
   end

   // one-way strap crosses in from a pin, so two stages first
   always @(posedge clk) begin
      if (!rst_n) begin
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         strap_s1_q <= one_way_lock_option;
         strap_s2_q <= strap_s1_q;
      end
   end

   // strap is latched while warm reset is held, then frozen for the run
   always @(posedge clk) begin
      if (!rst_n) begin
         one_way_cfg_q <= 1'b0;
      end else if (!warm_rst_n) begin
         one_way_cfg_q <= strap_s2_q;
      end
   end

   // unlock sequence: any other write in between breaks the key
   always @* begin
      seq_d  = seq_q;
      lock_d = selection_lock_flag;
      used_d = one_way_used_q;
      if (wr_fire) begin
         seq_d = SEQ_IDLE;
         if (hit_lock & lane0) begin
            case (seq_q)
               SEQ_IDLE: begin
                  if (dat_i[7:0] == `UNLOCK_KEY_A) begin
                     seq_d = SEQ_GOT_A;
                  end
               end
               SEQ_GOT_A: begin
                  if (dat_i[7:0] == `UNLOCK_KEY_B) begin
                     seq_d = SEQ_ARMED;
                  end else if (dat_i[7:0] == `UNLOCK_KEY_A) begin
                     seq_d = SEQ_GOT_A;
                  end
               end
               SEQ_ARMED: begin
                  // one-way: once set after a clear, stays until reset
                  if (!(one_way_cfg_q & one_way_used_q)) begin
                     lock_d = dat_i[`LOCK_BIT];
                     if (one_way_cfg_q & dat_i[`LOCK_BIT]) begin
                        used_d = 1'b1;
                     end
                  end
               end
               default: begin
                  seq_d = SEQ_IDLE;
               end
            endcase
         end
      end
   end

   // lock state clears on every reset; selections keep their value through warm reset
   always @(posedge clk) begin
      if (!rst_n || !warm_rst_n) begin
         selection_lock_flag <= `LOCK_RESET;
         seq_q               <= SEQ_IDLE;
         one_way_used_q      <= 1'b0;
      end else begin
         selection_lock_flag <= lock_d;
         seq_q               <= seq_d;
         one_way_used_q      <= used_d;
      end
   end

   // pins are asynchronous to clk
   always @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_q <= 24'h00_0000;
         pin_s2_q <= 24'h00_0000;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   genvar gi;
   genvar gc;

   // input selector index, byte address 0x040 plus 4 per index:
   //    0 external interrupt
   //    1 timer0 clock
   //    2 timer1 clock
   //    3 timer1 gate
   //    4 timer3 clock
   //    5 timer3 gate
   //    6 timer5 clock
   //    7 timer5 gate
   //    8 capture/compare one
   //    9 capture/compare two
   //   10 capture/compare three
   //   11 capture/compare four
   //   12 wavegen one
   //   13 wavegen two
   //   14 modulator carrier one
   //   15 modulator carrier two
   //   16 modulator source
   //   17 serial one clock
   //   18 serial one data
   //   19 serial one select
   //   20 serial two clock
   //   21 serial two data
   //   22 serial two select
   //   23 async receive
   //   24 logic cell in0
   //   25 logic cell in1
   //   26 logic cell in2
   //   27 logic cell in3
   // input codes: 0-5 port A, 12-15 port B4-B7, 16-23 port C0-C7
   // a reserved code parks the peripheral input low, never floating

   // input selectors: storage and routing, one per peripheral input
   generate
      for (gi = 0; gi < `NUM_IN_SEL; gi = gi + 1) begin : g_in
         always @(posedge clk) begin
            if (!rst_n) begin
               in_sel_q[gi] <= IN_SEL_DEFAULTS[gi*`SEL_W +: `SEL_W];
            end else if (sel_wr_ok && hit_in && in_idx == gi) begin
               in_sel_q[gi] <= dat_i[`SEL_W-1:0];
            end
         end

         // reserved codes (A6..A11 gap and 11xxx) feed a quiet low
         always @(posedge clk) begin
            if (!rst_n) begin
               periph_in_q[gi] <= 1'b0;
            end else if (in_sel_q[gi][4:3] == 2'b11) begin
               periph_in_q[gi] <= 1'b0;
            end else if ((in_sel_q[gi] >= `IN_CODE_RSVD_LO) &&
                         (in_sel_q[gi] <= `IN_CODE_RSVD_HI)) begin
               periph_in_q[gi] <= 1'b0;
            end else begin
               periph_in_q[gi] <= pin_s2_q[in_sel_q[gi]];
            end
         end
      end
   endgenerate

   // output code to source:
   //   31 data signal modulator
   //   30 reference clock
   //   29 numeric oscillator
   //   28 timer zero
   //   27 serial two data, marked
   //   26 serial two clock, marked
   //   25 serial one data
   //   24 serial one clock, marked
   //   23 comparator two
   //   22 comparator one
   //   21 async port sync data, marked
   //   20 async port transmit line, marked
   //   19 wavegen two d, marked
   //   18 wavegen two c, marked
   //   17 wavegen two b, marked
   //   16 wavegen two a, marked
   //   15 capture/compare four
   //   14 capture/compare three
   //   13 capture/compare two
   //   12 capture/compare one
   //   11 wavegen one d, marked
   //   10 wavegen one c, marked
   //    9 wavegen one b, marked
   //    8 wavegen one a, marked
   //    7 logic cell four
   //    6 logic cell three
   //    5 logic cell two
   //    4 logic cell one
   //    3 pwm unit six
   //    2 pwm unit five
   //    1 and 0 reserved
   // marked sources alone may take the pin driver direction

   assign dir_mask = `DIR_OVR_MASK;

   // per-code source level and override request, resolved once and
   // shared by all pins so each pin is a plain indexed pick
   generate
      for (gc = 0; gc < 32; gc = gc + 1) begin : g_src
         if (gc < 2) begin : g_rsvd
            assign src_level[gc] = 1'b0;
            assign src_ovr[gc]   = 1'b0;
         end else begin : g_live
            assign src_level[gc] = periph_out[gc];
            // unmarked sources never steal the direction control
            assign src_ovr[gc]   = periph_dir_req[gc] & dir_mask[gc];
         end
      end
   endgenerate

   // output pin index, byte address 0x100 plus 4 per index:
   //    0 port A pin 0
   //    1 port A pin 1
   //    2 port A pin 2
   //    3 port A pin 4
   //    4 port A pin 5
   //    5 port B pin 4
   //    6 port B pin 5
   //    7 port B pin 6, larger variant only
   //    8 port B pin 7, larger variant only
   //    9 port C pin 0
   //   10 port C pin 1
   //   11 port C pin 2
   //   12 port C pin 3
   //   13 port C pin 4
   //   14 port C pin 5
   //   15 port C pin 6, larger variant only
   //   16 port C pin 7, larger variant only

   // output selectors: storage and routing, one per pin
   generate
      for (gi = 0; gi < `NUM_OUT_PINS; gi = gi + 1) begin : g_out
         always @(posedge clk) begin
            if (!rst_n) begin
               out_sel_q[gi] <= `OUT_SEL_RESET;
            end else if (sel_wr_ok && hit_out && out_idx == gi) begin
               out_sel_q[gi] <= dat_i[`SEL_W-1:0];
            end
         end

         // code indexes the peripheral output bus directly; the reserved
         // codes give a steady low rather than an undefined source
         always @(posedge clk) begin
            if (!rst_n) begin
               pin_out_q[gi]     <= 1'b0;
               pin_dir_ovr_q[gi] <= 1'b0;
            end else if (out_sel_q[gi] == `OUT_CODE_RSVD0 ||
                         out_sel_q[gi] == `OUT_CODE_RSVD1) begin
               pin_out_q[gi]     <= 1'b0;
               pin_dir_ovr_q[gi] <= 1'b0;
            end else begin
               pin_out_q[gi]     <= src_level[out_sel_q[gi]];
               pin_dir_ovr_q[gi] <= src_ovr[out_sel_q[gi]];
            end
         end
      end
   endgenerate

endmodule

// *** tb/periph_model.sv ***
// Purpose: peripherals and pins on the far side of the matrix
// Assumes: the bench picks one active source and one high pin
// Notes:   source code 32 silences every peripheral
`timescale 1ns/100ps
module periph_model (
   // stimulus choice
   input  wire [5:0]  src_code,
   input  wire [4:0]  pin_code,
   // toward the matrix
   output wire [31:0] periph_out,
   output wire [31:0] periph_dir_req,
   output wire [23:0] pin_in
);
   // one-hot, so a wrong route reads as 0 instead of a lucky 1
   assign periph_out     = 32'h0000_0001 << src_code;
   assign periph_dir_req = periph_out;
   assign pin_in         = 24'h00_0001 << pin_code;
endmodule

// *** tb/pin_select_matrix_tb_top.sv ***
// Purpose: self-checking bench for the pin select matrix
// Assumes: one-wait-state classic Wishbone slave
// Notes:   routing is watched on pin 0 and input selector 0 only
`timescale 1ns/100ps
module pin_select_matrix_tb_top;
   logic        clk, rst_n, warm_rst_n, one_way_lock_option, cyc_i, stb_i, we_i;
   logic        ack_o, selection_lock_flag;
   logic [31:0] adr_i, dat_i, dat_o, periph_out, periph_dir_req, rd;
   logic [3:0]  sel_i;
   logic [27:0] periph_in_q;
   logic [23:0] pin_in;
   logic [16:0] pin_out_q, pin_dir_ovr_q;
   logic [5:0]  src_code;
   logic [4:0]  pin_code;
   int          n_fail, n_compared, i;
   // address, write byte, expected read byte
   logic [27:0] rows [6] = '{28'h100_FF1F, 28'h140_1C1C, 28'h040_E505, 28'h0AC_1717,
                             28'h400_5A00, 28'h000_FE00};
   pin_select_matrix DUT (.clk, .rst_n, .warm_rst_n, .one_way_lock_option, .cyc_i, .stb_i,
      .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .periph_out, .periph_dir_req,
      .periph_in_q, .pin_in, .pin_out_q, .pin_dir_ovr_q, .selection_lock_flag);
   periph_model u_far (.src_code, .pin_code, .periph_out, .periph_dir_req, .pin_in);
   // 10 MHz
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task chk(input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held until ack is sampled, then one idle cycle
   task wb(input logic w, input logic [31:0] a, d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk);
      while (ack_o !== 1'b1) @(posedge clk);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [31:0] a, d);
      wb(1'b1, a, d);
   endtask
   task rdv(input logic [31:0] a);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   task unlock(input logic [31:0] v);
      wr(0, 32'h0000_0055);
      wr(0, 32'h0000_00AA);
      wr(0, v);
   endtask
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watchdog, the run needs well under 2000 cycles
   initial begin
      #1_000_000;
      n_fail++;
      end_sim;
   end
   initial begin
      {rst_n, warm_rst_n, one_way_lock_option, cyc_i, stb_i, we_i} = '0;
      adr_i = '0;
      dat_i = '0;
      sel_i = 4'h1;
      src_code = 6'h20;
      pin_code = 5'h18;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      warm_rst_n <= 1'b1;
      @(posedge clk);
      rdv(32'h0000_0114);
      chk(rd, 0);
      chk(selection_lock_flag, 0);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         wr(rows[i][27:16], rows[i][15:8]);
         rdv(rows[i][27:16]);
         chk(rd, rows[i][7:0]);
      end
      $display("test registers done");
      // every output and input code, reserved ones included
      for (i = 0; i < 32; i++) begin
         src_code <= i;
         pin_code <= i;
         wr(32'h0000_0100, i);
         wr(32'h0000_0040, i);
         repeat (5) @(posedge clk);
         chk(pin_out_q[0], i > 1);
         chk(pin_dir_ovr_q[0], (32'h0D3F_0F00 >> i) & 1);
         chk(periph_in_q[0], i < 6 || (i > 11 && i < 24));
      end
      $display("test routing done");
      unlock(1);
      chk(selection_lock_flag, 1);
      wr(32'h0000_0100, 32'h0000_001C);
      wr(0, 0);
      rdv(32'h0000_0100);
      chk(rd, 32'h0000_001F);
      chk(selection_lock_flag, 1);
      unlock(0);
      wr(0, 32'h0000_0055);
      wr(32'h0000_0100, 32'h0000_001D);
      wr(0, 32'h0000_00AA);
      wr(0, 1);
      rdv(32'h0000_0100);
      chk(rd, 32'h0000_001D);
      chk(selection_lock_flag, 0);
      $display("test lock done");
      // warm reset latches the one-way strap and keeps selections
      unlock(1);
      one_way_lock_option <= 1'b1;
      warm_rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      warm_rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(selection_lock_flag, 0);
      rdv(32'h0000_0100);
      chk(rd, 32'h0000_001D);
      unlock(1);
      unlock(0);
      chk(selection_lock_flag, 1);
      $display("test one-way done");
      rst_n <= 1'b0;
      one_way_lock_option <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdv(32'h0000_0100);
      chk(rd, 0);
      chk(selection_lock_flag, 0);
      $display("test power-on reset done");
      end_sim;
   end
endmodule

// *** tb/pin_select_props.sv ***
// Purpose: port-level properties of the pin select matrix
// Assumes: one clock, rst_n is the synchronous power-on reset
// Notes:   marked override sources are worked out here, not taken from the design
`timescale 1ns/100ps
module pin_select_props (
   // clock and resets
   input wire        clk,
   input wire        rst_n,
   input wire        warm_rst_n,
   // wishbone
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [31:0] adr_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   // routing
   input wire [31:0] periph_out,
   input wire [31:0] periph_dir_req,
   input wire [23:0] pin_in,
   input wire [27:0] periph_in_q,
   input wire [16:0] pin_out_q,
   input wire [16:0] pin_dir_ovr_q,
   input wire        selection_lock_flag
);
   // codes 27 26 24 21 20 19-16 11-8 may take the pin driver
   localparam logic [31:0] DIR_MARKED = 32'h0D3F_0F00;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_timing: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack not a single pulse one cycle after request");
   a_lock_rd_zero: assert property (ack_o && !we_i && adr_i == 0 |-> dat_o[31:1] == 0)
      else $error("lock register upper bits not zero");
   a_out_rd_zero: assert property (ack_o && !we_i && adr_i[9:8] == 2'b01 |-> dat_o[31:5] == 0)
      else $error("output selector upper bits not zero");
   a_in_rd_zero: assert property (ack_o && !we_i && adr_i[9:8] == 0 && adr_i[7:6] != 0
      |-> dat_o[31:5] == 0) else $error("input selector upper bits not zero");
   a_lock_cause: assert property ($changed(selection_lock_flag)
      |-> $past(ack_o && we_i && adr_i == 0) || !$past(warm_rst_n))
      else $error("lock flag changed without a lock write");
   a_dir_marked: assert property ($past(periph_dir_req & DIR_MARKED) == 0
      |-> pin_dir_ovr_q == 0) else $error("override from an unmarked source");
   a_out_from_src: assert property ($past(periph_out) == 0 |-> pin_out_q == 0)
      else $error("pin driven with no active source");
   a_in_from_pin: assert property ($past(pin_in) == 0 && $past(pin_in, 2) == 0
      && $past(pin_in, 3) == 0 |-> periph_in_q == 0) else $error("input with no pin high");
   a_por_clear: assert property (disable iff (1'b0) !rst_n
      |=> !selection_lock_flag && pin_out_q == 0) else $error("power-on reset not clearing");
endmodule

bind pin_select_matrix pin_select_props u_props (.clk, .rst_n, .warm_rst_n, .cyc_i, .stb_i,
   .we_i, .adr_i, .dat_o, .ack_o, .periph_out, .periph_dir_req, .pin_in, .periph_in_q,
   .pin_out_q, .pin_dir_ovr_q, .selection_lock_flag);
